// ### common/pman_pkg.sv
// package: register map, fields, reset values and timing of the media/negotiation block
package pman_pkg;
    // ****************************************
    // register word indexes (byte address = 4 * index)
    // ****************************************
    localparam logic [4:0] IDX_BASIC_MODE_CONTROL   = 5'h00;
    localparam logic [4:0] IDX_BASIC_MODE_STATUS    = 5'h01;
    localparam logic [4:0] IDX_AUTONEG_ADVERTISE    = 5'h04;
    localparam logic [4:0] IDX_LINK_PARTNER_ABILITY = 5'h05;
    localparam logic [4:0] IDX_AUTONEG_EXPANSION    = 5'h06;
    localparam logic [4:0] IDX_PHY_LINK_STATUS      = 5'h10;
    localparam logic [4:0] IDX_PCS_SUBLAYER_CONTROL = 5'h16;
    localparam logic [4:0] IDX_PHY_CONTROL          = 5'h19;
    // ****************************************
    // field positions
    // ****************************************
    localparam int CTL_SPEED      = 13;
    localparam int CTL_AN_ENABLE  = 12;
    localparam int CTL_RESTART    = 9;
    localparam int CTL_DUPLEX     = 8;
    localparam int ADV_100_FULL   = 8;
    localparam int ADV_100_HALF   = 7;
    localparam int ADV_10_FULL    = 6;
    localparam int ADV_10_HALF    = 5;
    localparam int LP_NEXT_PAGE   = 15;
    localparam int LP_REMOTE_FLT  = 13;
    localparam int PCS_FIBER_EN   = 6;
    localparam int PCS_FEF_EN     = 3;
    localparam int PCS_SCR_BYPASS = 1;
    localparam int PCS_DSC_BYPASS = 0;
    localparam int PHC_AUTO_XOVER = 15;
    localparam int PHC_FORCE_XOVER = 14;
    // ****************************************
    // values
    // ****************************************
    localparam logic [15:0] BASIC_STATUS_FIXED = 16'h7849;
    localparam logic [15:0] LP_PARALLEL_100    = 16'h0081;
    localparam logic [15:0] LP_PARALLEL_10     = 16'h0021;
    localparam logic [15:0] ADVERTISE_RESET    = 16'h01E1;
    localparam logic [15:0] PHY_CONTROL_RESET  = 16'h8000;
    localparam logic [15:0] PCS_FIBER_BITS     = 16'h004B;
    localparam logic [3:0]  ADV_ALL            = 4'hF;
    localparam logic [1:0]  STRAP_SETTLE       = 2'h3;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_KHZ          = 25000;
    localparam int BREAK_LINK_MS    = 1500;
    localparam int BREAK_LINK_COUNT = BREAK_LINK_MS * CLK_KHZ;
    localparam int XOVER_SLOT_US    = 2500;
    localparam int XOVER_SLOT_COUNT = XOVER_SLOT_US * CLK_KHZ / 1000;

    typedef struct packed {
        logic rx_error_level;
        logic negotiate_strap;
        logic mode_strap_high;
        logic mode_strap_low;
    } pman_strap_type;

    typedef struct packed {
        logic link_up;
        logic speed_100;
        logic full_duplex;
        logic fiber_media_select;
    } pman_link_type;
endpackage

// ### design/pman_core.sv
// media select, link negotiation, crossover control and its register slave
`timescale 1ns/1ps
// Overview of operation
// - receive-error strap picks media at reset; low selects fiber.
// - fiber strap also sets far-end fault, scramble and descramble bypass.
// - software picks media through fiber-enable bit 6 at index 16h.
// - negotiate strap low: mode straps force 10/100 and half/full.
// - negotiate strap high: mode straps pick the advertised ability set.
// - strap values initialise advertise bits 8 to 5.
// - basic control writes override strap behaviour after reset; enabling negotiation needs enable written clear first.
// - with negotiation on, advertise word goes out in link pulse bursts.
// - resolve 100 full, 100 half, 10 full, then 10 half.
// - negotiation off: speed and duplex bits rule; ignored while it is on.
// - link status register shows resolved speed once link is up.
// - basic status ability bits fixed; the T4 bit reads zero.
// - basic status shows complete, remote fault, link, preamble suppression.
// - advertise defaults to all abilities; cleared ones leave negotiation.
// - partner register takes each page outside break and forced mode; parallel detect gives 0081h/0021h.
// - expansion: detect fault, partner/local next page, page received, able.
// - parallel detect uses both receivers' link; partner-able stays zero.
// - parallel detect with both receivers' links good sets the fault flag.
// - restart bit 9 or loss of negotiated link restarts negotiation.
// - renegotiation silences transmit for the break timer, then sends bursts.
// - crossover auto after reset, bit 14 forces it, no auto in forced mode.
module pman_core #(
    parameter int BREAK_LINK_CYCLES = pman_pkg::BREAK_LINK_COUNT,
    parameter int XOVER_SLOT_CYCLES = pman_pkg::XOVER_SLOT_COUNT
) (
    input  wire logic                    ref_clk,
    input  wire logic                    rst,
    input  wire logic [4:0]              avs_address,
    input  wire logic                    avs_read,
    input  wire logic                    avs_write,
    input  wire logic [3:0]              avs_byteenable,
    input  wire logic [31:0]             avs_writedata,
    output logic      [31:0]             avs_readdata,
    output logic                         avs_waitrequest,
    input  wire pman_pkg::pman_strap_type strap_pins,
    input  wire logic                    rx_link_good_10,
    input  wire logic                    rx_link_good_100,
    input  wire logic                    page_valid,
    input  wire logic [15:0]             page_word,
    output logic                         flp_send,
    output logic [15:0]                  flp_word,
    output logic                         tx_quiet,
    output pman_pkg::pman_link_type      link_state,
    output logic                         crossover_select
);
    typedef enum logic [2:0] {
        ST_FORCED, ST_BREAK, ST_DETECT, ST_WAIT_LINK, ST_DONE
    } pman_state_type;

    if (BREAK_LINK_CYCLES < 2 || BREAK_LINK_CYCLES > 2**26 - 1)
        $error("BREAK_LINK_CYCLES out of range");
    if (XOVER_SLOT_CYCLES < 2 || XOVER_SLOT_CYCLES > 2**20 - 1)
        $error("XOVER_SLOT_CYCLES out of range");

    localparam logic [25:0] BREAK_END = 26'(BREAK_LINK_CYCLES - 1);
    localparam logic [19:0] SLOT_END  = 20'(XOVER_SLOT_CYCLES - 1);

    // ****************************************
    // synchronisers and strap capture
    // ****************************************
    pman_pkg::pman_strap_type strap_meta, strap_sync;
    logic [1:0]               link_meta, link_sync;
    logic [1:0]               settle;
    logic                     strap_done;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            strap_meta <= '0;
            strap_sync <= '0;
            link_meta  <= 2'h0;
            link_sync  <= 2'h0;
        end
        else
        begin
            strap_meta <= strap_pins;
            strap_sync <= strap_meta;
            link_meta  <= {rx_link_good_100, rx_link_good_10};
            link_sync  <= link_meta;
        end
    end

    // captured once, after the pins have crossed the synchroniser
    wire capture_now = !strap_done && settle == pman_pkg::STRAP_SETTLE;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            settle     <= 2'h0;
            strap_done <= 1'b0;
        end
        else
        begin
            settle     <= strap_done ? settle : settle + 2'h1;
            strap_done <= strap_done | capture_now;
        end
    end

    wire       strap_fiber = !strap_sync.rx_error_level;
    wire [1:0] strap_mode  = {strap_sync.mode_strap_high,
                              strap_sync.mode_strap_low};
    logic [3:0] strap_adv;
    always_comb
    begin
        case (strap_mode)
            2'h0:    strap_adv = 4'h3;
            2'h1:    strap_adv = 4'hC;
            2'h2:    strap_adv = 4'h8;
            default: strap_adv = pman_pkg::ADV_ALL;
        endcase
        if (!strap_sync.negotiate_strap)
            strap_adv = pman_pkg::ADV_ALL;
    end

    // ****************************************
    // bus slave
    // ****************************************
    logic        ack;
    logic [15:0] basic_mode_control, autoneg_advertise, lpar, pcs_sublayer_control, phy_control;
    logic        an_armed, pd_fault, page_rcvd, lp_an_able, lp_np;
    pman_state_type state;

    wire req      = (avs_read | avs_write) & strap_done;
    wire wr_ack   = ack & avs_write;
    wire rd_ack   = ack & avs_read;
    wire [15:0] wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire [15:0] wdat  = avs_writedata[15:0];
    wire wr_basic_mode_control  = wr_ack && avs_address == pman_pkg::IDX_BASIC_MODE_CONTROL;
    wire wr_autoneg_advertise  = wr_ack && avs_address == pman_pkg::IDX_AUTONEG_ADVERTISE;
    wire wr_pcs_sublayer_control  = wr_ack && avs_address == pman_pkg::IDX_PCS_SUBLAYER_CONTROL;
    wire wr_phy_control = wr_ack && avs_address == pman_pkg::IDX_PHY_CONTROL;
    wire rd_autoneg_expansion  = rd_ack && avs_address == pman_pkg::IDX_AUTONEG_EXPANSION;
    wire [15:0] basic_mode_control_new  = (basic_mode_control & ~wmask) | (wdat & wmask);
    wire [15:0] autoneg_advertise_new  = (autoneg_advertise & ~wmask) | (wdat & wmask);
    wire [15:0] pcs_sublayer_control_new  = (pcs_sublayer_control & ~wmask) | (wdat & wmask);
    wire [15:0] phy_control_new = (phy_control & ~wmask) | (wdat & wmask);

    wire an_active = basic_mode_control[pman_pkg::CTL_AN_ENABLE] & an_armed;
    wire an_rise   = wr_basic_mode_control && an_armed && basic_mode_control_new[pman_pkg::CTL_AN_ENABLE]
                     && !basic_mode_control[pman_pkg::CTL_AN_ENABLE];
    wire restart_wr = wr_basic_mode_control && basic_mode_control_new[pman_pkg::CTL_RESTART];
    wire link_any  = link_sync[0] | link_sync[1];
    wire link_lost = state == ST_DONE && !link_any;
    wire renegotiate = an_active && (restart_wr || link_lost) || an_rise;

    wire [15:0] basic_mode_status = pman_pkg::BASIC_STATUS_FIXED
                     | {10'h0, state == ST_DONE, lpar[pman_pkg::LP_REMOTE_FLT],
                        1'b0, link_state.link_up, 2'h0};
    wire [15:0] autoneg_expansion = {11'h0, pd_fault, lp_np, 1'b0, page_rcvd,
                        lp_an_able};
    wire [15:0] phy_link_status = {11'h0, state == ST_DONE, 1'b0,
                          link_state.full_duplex, !link_state.speed_100,
                          link_state.link_up};
    logic [15:0] rd_mux;
    always_comb
    begin
        case (avs_address)
            pman_pkg::IDX_BASIC_MODE_CONTROL:   rd_mux = basic_mode_control;
            pman_pkg::IDX_BASIC_MODE_STATUS:    rd_mux = basic_mode_status;
            pman_pkg::IDX_AUTONEG_ADVERTISE:    rd_mux = autoneg_advertise;
            pman_pkg::IDX_LINK_PARTNER_ABILITY: rd_mux = lpar;
            pman_pkg::IDX_AUTONEG_EXPANSION:    rd_mux = autoneg_expansion;
            pman_pkg::IDX_PHY_LINK_STATUS:      rd_mux = phy_link_status;
            pman_pkg::IDX_PCS_SUBLAYER_CONTROL: rd_mux = pcs_sublayer_control;
            pman_pkg::IDX_PHY_CONTROL:          rd_mux = phy_control;
            default:                            rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ack             <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end
        else
        begin
            ack             <= req & !ack;
            avs_waitrequest <= !(req & !ack);
            avs_readdata    <= {16'h0000, rd_mux};
        end
    end

    // ****************************************
    // configuration registers
    // ****************************************
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            basic_mode_control     <= 16'h0000;
            autoneg_advertise     <= pman_pkg::ADVERTISE_RESET;
            pcs_sublayer_control     <= 16'h0000;
            phy_control    <= pman_pkg::PHY_CONTROL_RESET;
            an_armed <= 1'b0;
        end
        else if (capture_now)
        begin
            basic_mode_control     <= {2'h0, strap_mode[1], strap_sync.negotiate_strap,
                         3'h0, strap_mode[0], 8'h00};
            autoneg_advertise     <= {7'h00, strap_adv, 5'h01};
            pcs_sublayer_control     <= strap_fiber ? pman_pkg::PCS_FIBER_BITS
                                    : 16'h0000;
            an_armed <= strap_sync.negotiate_strap;
        end
        else
        begin
            if (wr_basic_mode_control)
                basic_mode_control <= basic_mode_control_new & ~(16'h1 << pman_pkg::CTL_RESTART);
            if (wr_basic_mode_control && !basic_mode_control_new[pman_pkg::CTL_AN_ENABLE])
                an_armed <= 1'b1;
            if (wr_autoneg_advertise)
                autoneg_advertise <= autoneg_advertise_new;
            if (wr_pcs_sublayer_control)
                pcs_sublayer_control <= pcs_sublayer_control_new;
            if (wr_phy_control)
                phy_control <= phy_control_new;
        end
    end

    // ****************************************
    // negotiation sequencer
    // ****************************************
    wire [3:0] common = autoneg_advertise[8:5] & lpar[8:5];
    wire res_valid = |common;
    wire res_100   = common[3] | common[2];
    wire res_full  = common[3] | (!common[2] & common[1]);
    wire res_link  = res_100 ? link_sync[1] : link_sync[0];
    wire pd_one    = link_sync[0] ^ link_sync[1];
    logic [25:0] break_cnt;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state      <= ST_FORCED;
            break_cnt  <= 26'h0;
            lpar       <= 16'h0000;
            pd_fault   <= 1'b0;
            page_rcvd  <= 1'b0;
            lp_an_able <= 1'b0;
            lp_np      <= 1'b0;
        end
        else
        begin
            break_cnt <= state == ST_BREAK ? break_cnt + 26'h1 : 26'h0;
            if (rd_autoneg_expansion)
                pd_fault <= 1'b0;
            if (rd_autoneg_expansion)
                page_rcvd <= 1'b0;
            if (!an_active)
                state <= ST_FORCED;
            else if (renegotiate || state == ST_FORCED)
                state <= ST_BREAK;
            else
            begin
                case (state)
                    ST_BREAK:
                        if (break_cnt == BREAK_END)
                            state <= ST_DETECT;
                    ST_DETECT:
                        if (!page_valid && pd_one)
                        begin
                            lpar  <= link_sync[1] ? pman_pkg::LP_PARALLEL_100
                                                  : pman_pkg::LP_PARALLEL_10;
                            state <= ST_DONE;
                        end
                        else if (!page_valid && link_sync == 2'h3)
                            pd_fault <= 1'b1;
                    ST_WAIT_LINK:
                        if (res_valid && res_link)
                            state <= ST_DONE;
                    default:
                        state <= state;
                endcase
                if (page_valid && state != ST_BREAK)
                begin
                    lpar       <= page_word;
                    page_rcvd  <= 1'b1;
                    lp_an_able <= 1'b1;
                    lp_np      <= page_word[pman_pkg::LP_NEXT_PAGE];
                    if (state == ST_DETECT)
                        state <= ST_WAIT_LINK;
                end
            end
            if (state == ST_BREAK)
                lp_an_able <= 1'b0;
        end
    end

    // ****************************************
    // outputs and crossover
    // ****************************************
    logic [19:0] slot_cnt;
    logic [7:0]  lfsr;
    wire auto_xover = phy_control[pman_pkg::PHC_AUTO_XOVER] && an_active
                      && state == ST_DETECT;
    wire fiber_now  = pcs_sublayer_control[pman_pkg::PCS_FIBER_EN];
    wire forced_100 = basic_mode_control[pman_pkg::CTL_SPEED];
    wire forced_up  = forced_100 ? link_sync[1] : link_sync[0];

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            flp_send         <= 1'b0;
            flp_word         <= 16'h0000;
            tx_quiet         <= 1'b0;
            link_state       <= '0;
            crossover_select <= 1'b0;
            slot_cnt         <= 20'h0;
            lfsr             <= 8'h01;
        end
        else
        begin
            flp_send <= state == ST_DETECT || state == ST_WAIT_LINK;
            flp_word <= autoneg_advertise;
            tx_quiet <= state == ST_BREAK;
            link_state.fiber_media_select <= fiber_now;
            if (state == ST_FORCED)
            begin
                link_state.speed_100   <= forced_100;
                link_state.full_duplex <= basic_mode_control[pman_pkg::CTL_DUPLEX];
                link_state.link_up     <= forced_up;
            end
            else
            begin
                link_state.link_up <= state == ST_DONE && link_any;
                if (state == ST_WAIT_LINK)
                begin
                    link_state.speed_100   <= res_100;
                    link_state.full_duplex <= res_full;
                end
                else if (state == ST_DETECT)
                begin
                    link_state.speed_100   <= link_sync[1];
                    link_state.full_duplex <= 1'b0;
                end
            end
            lfsr     <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
            slot_cnt <= (slot_cnt == SLOT_END || !auto_xover) ? 20'h0
                                                              : slot_cnt + 20'h1;
            if (phy_control[pman_pkg::PHC_FORCE_XOVER])
                crossover_select <= 1'b1;
            else if (!auto_xover && state != ST_DONE)
                crossover_select <= 1'b0;
            else if (auto_xover && slot_cnt == SLOT_END && lfsr[0])
                crossover_select <= !crossover_select;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    sequence restart_write_s;
        wr_basic_mode_control && an_active && basic_mode_control_new[pman_pkg::CTL_RESTART];
    endsequence
    sequence break_seen_s;
        state == ST_BREAK ##1 tx_quiet;
    endsequence

    restart_break_a: assert property (@(posedge ref_clk) disable iff (rst)
        restart_write_s |=> break_seen_s)
        else $error("restart did not enter break");
    quiet_break_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(tx_quiet) |-> $past(state == ST_BREAK) && !flp_send)
        else $error("quiet without break");
    wait_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    fiber_strap_a: assert property (@(posedge ref_clk) disable iff (rst)
        capture_now && strap_fiber |=> pcs_sublayer_control == pman_pkg::PCS_FIBER_BITS)
        else $error("fiber strap bits not set");
    parallel_word_a: assert property (@(posedge ref_clk) disable iff (rst)
        $past(state) == ST_DETECT && state == ST_DONE |->
        lpar == pman_pkg::LP_PARALLEL_100 || lpar == pman_pkg::LP_PARALLEL_10)
        else $error("bad partner word after parallel detect");
    status_fixed_a: assert property (@(posedge ref_clk) disable iff (rst)
        !avs_waitrequest && $past(avs_read && avs_address ==
        pman_pkg::IDX_BASIC_MODE_STATUS) |-> avs_readdata[15:11] == 5'h0F)
        else $error("basic status abilities wrong");
    priority_top_a: assert property (@(posedge ref_clk) disable iff (rst)
        state == ST_WAIT_LINK && common[3] |=> link_state.speed_100
        && link_state.full_duplex)
        else $error("priority resolution wrong");
    forced_speed_a: assert property (@(posedge ref_clk) disable iff (rst)
        state == ST_FORCED ##1 state == ST_FORCED |->
        link_state.speed_100 == $past(basic_mode_control[pman_pkg::CTL_SPEED]))
        else $error("forced speed not followed");
    force_xover_a: assert property (@(posedge ref_clk) disable iff (rst)
        phy_control[pman_pkg::PHC_FORCE_XOVER] |=> crossover_select)
        else $error("forced crossover not applied");
    strap_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        strap_done |=> strap_done && !capture_now)
        else $error("straps captured twice");
endmodule

// ### test/pman_link_partner.sv
// far-end link partner: pages on request and receiver link levels
`timescale 1ns/1ps
module pman_link_partner (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        flp_send,
    input  wire logic        tx_quiet,
    input  wire logic [15:0] lp_word,
    input  wire logic        lp_negotiates,
    input  wire logic        lp_link_10,
    input  wire logic        lp_link_100,
    output logic             page_valid,
    output logic      [15:0] page_word,
    output logic             rx_link_good_10,
    output logic             rx_link_good_100
);
    logic [1:0] gap;
    wire        send_page = lp_negotiates && flp_send && !tx_quiet
                            && gap == 2'h0;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            gap <= 2'h0;
            page_valid <= 1'b0;
            page_word <= 16'h0000;
            rx_link_good_10 <= 1'b0;
            rx_link_good_100 <= 1'b0;
        end
        else
        begin
            gap <= gap + 2'h1;
            page_valid <= send_page;
            // a stale word would look valid, so it flips between pages
            page_word <= send_page ? lp_word : ~page_word;
            rx_link_good_10 <= lp_link_10 && !tx_quiet;
            rx_link_good_100 <= lp_link_100 && !tx_quiet;
        end
    end
endmodule

// ### test/pman_core_bench.sv
// bench: straps, bus registers, detect, negotiation and forced modes
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
    num_errors++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); \
    end end
module pman_core_bench;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest, page_valid, flp_send, tx_quiet;
    logic        rx_link_good_10, rx_link_good_100, crossover_select;
    logic        lp_negotiates = 1'b0, lp_link_10 = 1'b0, lp_link_100 = 1'b0;
    logic [15:0] page_word, flp_word, q, lp_word = 16'h0000;
    int          num_errors = 0, check_count = 0;
    pman_pkg::pman_strap_type strap_pins = 4'hF;
    pman_pkg::pman_link_type  link_state;
    pman_core #(.BREAK_LINK_CYCLES(20), .XOVER_SLOT_CYCLES(8)) u_pman_core (
        .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'h3),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .strap_pins(strap_pins),
        .rx_link_good_10(rx_link_good_10), .page_valid(page_valid),
        .rx_link_good_100(rx_link_good_100), .page_word(page_word),
        .flp_send(flp_send), .flp_word(flp_word), .tx_quiet(tx_quiet),
        .link_state(link_state), .crossover_select(crossover_select));
    pman_link_partner u_pman_link_partner (
        .ref_clk(ref_clk), .rst(rst), .flp_send(flp_send),
        .tx_quiet(tx_quiet), .lp_word(lp_word), .lp_negotiates(lp_negotiates),
        .lp_link_10(lp_link_10), .lp_link_100(lp_link_100),
        .page_valid(page_valid), .page_word(page_word),
        .rx_link_good_10(rx_link_good_10), .rx_link_good_100(rx_link_good_100));
    always #20 ref_clk = ~ref_clk;
    task automatic test_done;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [15:0] d);
        int n;
        @(posedge ref_clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        q = avs_readdata[15:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 100)
        begin
            num_errors++;
            test_done;
        end
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        bus(1'b0, a, 16'h0000);
        `CHK(q, e)
    endtask
    task automatic wait_sig(input int which, input logic v);
        logic s;
        for (int n = 0; n < 3000; n++)
        begin
            @(posedge ref_clk);
            s = which == 0 ? link_state.link_up
              : which == 1 ? tx_quiet : flp_send;
            if (s === v)
                return;
        end
        num_errors++;
        test_done;
    endtask
    task automatic do_reset(input logic [3:0] s);
        @(posedge ref_clk);
        rst <= 1'b1;
        strap_pins <= s;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (6) @(posedge ref_clk);
    endtask
    task automatic t_straps;
        logic [15:0] adv [4] = '{16'h0061, 16'h0181, 16'h0101, 16'h01E1};
        for (int m = 0; m < 4; m++)
        begin
            do_reset({2'b11, m[1:0]});
            rd(5'h04, adv[m]);
        end
        strap_pins <= 4'h0;
        rd(5'h04, 16'h01E1);
        rd(5'h16, 16'h0000);
        rd(5'h19, 16'h8000);
        bus(1'b1, 5'h01, 16'hFFFF);
        rd(5'h01, 16'h7849);
        rd(5'h1F, 16'h0000);
    endtask
    task automatic t_parallel;
        lp_link_10 <= 1'b1;
        lp_link_100 <= 1'b1;
        repeat (30) @(posedge ref_clk);
        bus(1'b0, 5'h06, 16'h0000);
        `CHK(q[4], 1'b1)
        lp_link_100 <= 1'b0;
        wait_sig(0, 1'b1);
        `CHK({link_state.speed_100, link_state.full_duplex}, 2'b00)
        rd(5'h05, 16'h0021);
        bus(1'b0, 5'h06, 16'h0000);
        `CHK(q[0], 1'b0)
        bus(1'b0, 5'h10, 16'h0000);
        `CHK(q[2:0], 3'h3)
        lp_link_10 <= 1'b0;
        wait_sig(1, 1'b1);
        `CHK(flp_send, 1'b0)
    endtask
    task automatic t_negotiate;
        bus(1'b1, 5'h04, 16'h0161);
        bus(1'b1, 5'h00, 16'h1200);
        wait_sig(1, 1'b1);
        wait_sig(1, 1'b0);
        wait_sig(2, 1'b1);
        `CHK(flp_word, 16'h0161)
        lp_word <= 16'h01E1;
        lp_negotiates <= 1'b1;
        repeat (10) @(posedge ref_clk);
        lp_negotiates <= 1'b0;
        rd(5'h05, 16'h01E1);
        bus(1'b0, 5'h06, 16'h0000);
        `CHK(q[1:0], 2'h3)
        lp_link_100 <= 1'b1;
        wait_sig(0, 1'b1);
        `CHK({link_state.speed_100, link_state.full_duplex}, 2'b11)
        bus(1'b0, 5'h10, 16'h0000);
        `CHK(q[2:0], 3'h5)
        bus(1'b0, 5'h01, 16'h0000);
        `CHK(q[5], 1'b1)
    endtask
    task automatic t_forced;
        lp_link_100 <= 1'b0;
        do_reset(4'b0010);
        rd(5'h16, 16'h004B);
        `CHK(link_state.fiber_media_select, 1'b1)
        lp_link_100 <= 1'b1;
        wait_sig(0, 1'b1);
        `CHK({link_state.speed_100, link_state.full_duplex}, 2'b10)
        repeat (40) @(posedge ref_clk);
        `CHK(crossover_select, 1'b0)
        bus(1'b1, 5'h00, 16'h3000);
        repeat (10) @(posedge ref_clk);
        `CHK(tx_quiet, 1'b0)
        bus(1'b1, 5'h00, 16'h0100);
        repeat (4) @(posedge ref_clk);
        `CHK({link_state.speed_100, link_state.full_duplex}, 2'b01)
        bus(1'b1, 5'h19, 16'h4000);
        repeat (4) @(posedge ref_clk);
        `CHK(crossover_select, 1'b1)
        bus(1'b1, 5'h16, 16'h0000);
        repeat (4) @(posedge ref_clk);
        `CHK(link_state.fiber_media_select, 1'b0)
        // enable cleared above, so setting it now must start a break
        bus(1'b1, 5'h00, 16'h1000);
        wait_sig(1, 1'b1);
        `CHK(flp_send, 1'b0)
    endtask
    initial
    begin
        t_straps;
        t_parallel;
        t_negotiate;
        t_forced;
        test_done;
    end
endmodule
